// ===== include/icd_regs.vh
// constants of the instruction class dispatch block
`ifndef ICD_REGS_VH
`define ICD_REGS_VH
`define ICD_W          16
`define ICD_OP_MSB     15
`define ICD_OP_LSB     12
`define ICD_ADR_MSB    11
`define ICD_ADR_LSB    0
`define ICD_KEY_W      5
`define ICD_NCNT       29
`define ICD_CNT_W      5
// class codes
`define ICD_CL_REG     2'h0
`define ICD_CL_INV     2'h1
`define ICD_CL_PER     2'h2
// regular kinds
`define ICD_K_BASIC    2'h0
`define ICD_K_EXTRA    2'h1
`define ICD_K_CHAN     2'h2
`define ICD_K_SPEC     2'h3
// function groups
`define ICD_F_SEQ      4'h0
`define ICD_F_COPY     4'h1
`define ICD_F_XCH      4'h2
`define ICD_F_STORE    4'h3
`define ICD_F_MOD      4'h4
`define ICD_F_ARITH    4'h5
`define ICD_F_ADDST    4'h6
`define ICD_F_INCR     4'h7
`define ICD_F_ANG      4'h8
`define ICD_F_AND      4'h9
`define ICD_F_CHRD     4'ha
`define ICD_F_CHWR     4'hb
`define ICD_F_SPEC     4'hc
`define ICD_F_INTR     4'hd
`define ICD_F_CNT      4'he
`define ICD_F_PERI     4'hf
// special words (order code zero with these addresses)
`define ICD_SP_RELINT  12'h003
`define ICD_SP_INHINT  12'h004
`define ICD_SP_EXTEND  12'h006
`define ICD_SP_RESUME  12'h00f
// interrupt order code, vectors and counter base address
`define ICD_OP_INTR    4'h0
`define ICD_VEC_INIT   12'h800
`define ICD_VEC_KEY    12'h814
`define ICD_VEC_PROG   12'h810
`define ICD_CNT_BASE   12'h024
`endif

// ===== hdl/icd_class_decode.v
// combinational order code to class and function decoder
`timescale 1ns/100ps
`include "icd_regs.vh"
module icd_class_decode (
  input  wire [`ICD_W-1:0] word,
  input  wire              ext,
  output reg  [1:0]        kind,
  output reg  [3:0]        func,
  output reg  [1:0]        sub,
  output reg               is_extend,
  output reg               is_prog_intr
);
  wire [3:0]  op  = word[`ICD_OP_MSB:`ICD_OP_LSB];
  wire [11:0] adr = word[`ICD_ADR_MSB:`ICD_ADR_LSB];

  // sort word into kind, group and sub operation
  always @* begin
    kind         = `ICD_K_BASIC;
    func         = `ICD_F_SEQ;
    sub          = 2'h0;
    is_extend    = 1'b0;
    is_prog_intr = 1'b0;
    if (!ext && op == 4'h0 &&
        (adr == `ICD_SP_RELINT || adr == `ICD_SP_INHINT ||
         adr == `ICD_SP_EXTEND || adr == `ICD_SP_RESUME)) begin
      kind      = `ICD_K_SPEC;
      func      = `ICD_F_SPEC;
      sub       = adr[1:0];
      is_extend = (adr == `ICD_SP_EXTEND);
      is_prog_intr = (adr == `ICD_SP_RESUME);
    end else if (!ext) begin
      case (op)
        4'h0, 4'h1: func = `ICD_F_SEQ;
        4'h2: func = `ICD_F_COPY;
        4'h3: func = `ICD_F_XCH;
        4'h4: func = `ICD_F_STORE;
        4'h5: func = `ICD_F_MOD;
        4'h6, 4'h7: begin
          func = `ICD_F_ARITH;
          sub  = {1'b0, op[0]};
        end
        4'h8, 4'h9: begin
          func = `ICD_F_ADDST;
          sub  = {1'b0, op[0]};
        end
        4'ha: begin
          func = `ICD_F_INCR;
          sub  = adr[11:10];
        end
        4'hb: func = `ICD_F_AND;
        default: func = `ICD_F_SEQ;
      endcase
    end else begin
      case (op)
        4'h0: begin
          kind = `ICD_K_CHAN;
          func = adr[11] ? `ICD_F_CHWR : `ICD_F_CHRD;
          sub  = adr[10:9];
        end
        4'h1: begin
          kind = `ICD_K_EXTRA;
          func = `ICD_F_SEQ;
        end
        4'h2, 4'h3: begin
          kind = `ICD_K_EXTRA;
          func = `ICD_F_ARITH;
          sub  = {1'b1, op[0]};
        end
        4'h4: begin
          kind = `ICD_K_EXTRA;
          func = `ICD_F_ANG;
        end
        default: begin
          kind = `ICD_K_EXTRA;
          func = `ICD_F_MOD;
        end
      endcase
    end
  end
endmodule // icd_class_decode

// ===== hdl/icd_dispatch.v
// instruction class dispatcher with keyboard path and involuntary arbitration
`timescale 1ns/100ps
`include "icd_regs.vh"
module icd_dispatch (
  input  wire                  clk,
  input  wire                  resetn,
  input  wire                  key_press_a,
  input  wire [`ICD_KEY_W-1:0] key_code_a,
  input  wire                  key_press_b,
  input  wire [`ICD_KEY_W-1:0] key_code_b,
  input  wire                  key_chan_rd,
  input  wire                  power_on_req,
  input  wire                  trap_req,
  input  wire                  rupt_req,
  input  wire [11:0]           rupt_vec,
  input  wire [3:0]            cnt_req,
  input  wire [`ICD_CNT_W-1:0] cnt_sel,
  input  wire                  per_req,
  input  wire                  per_tape,
  input  wire [`ICD_W-1:0]     mem_word,
  input  wire                  mem_valid,
  input  wire                  instr_done,
  output wire                  mem_ready,
  output reg  [`ICD_KEY_W-1:0] key_chan_r,
  output reg                   key_chan_full_r,
  output reg                   key_irq_r,
  output reg                   issue_r,
  output reg  [1:0]            class_r,
  output reg  [1:0]            kind_r,
  output reg  [3:0]            func_r,
  output reg  [1:0]            sub_r,
  output reg  [3:0]            order_r,
  output reg  [11:0]           addr_r,
  output reg                   ext_r,
  output reg                   inhibit_r,
  output reg                   monitor_stop_r,
  output reg                   chan_space_r
);
  // ==========================================================
  // states
  localparam ST_IDLE = 3'b001;
  localparam ST_BUSY = 3'b010;
  localparam ST_PERI = 3'b100;

  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg        key_a_s1_r;
  reg        key_a_s2_r;
  reg        key_a_s3_r;
  reg        key_b_s1_r;
  reg        key_b_s2_r;
  reg        key_b_s3_r;
  reg [`ICD_KEY_W-1:0] code_a_s1_r;
  reg [`ICD_KEY_W-1:0] code_a_s2_r;
  reg [`ICD_KEY_W-1:0] code_b_s1_r;
  reg [`ICD_KEY_W-1:0] code_b_s2_r;
  reg        per_s1_r;
  reg        per_s2_r;
  reg        init_pend_r;
  reg        prog_rupt_r;
  reg        first_basic_r;

  wire [1:0] dk_kind;
  wire [3:0] dk_func;
  wire [1:0] dk_sub;
  wire       dk_ext;
  wire       dk_prog;

  // counter address limited to 29 slots
  function [11:0] cnt_addr;
    input [`ICD_CNT_W-1:0] s;
    begin
      if (s < `ICD_NCNT)
        cnt_addr = `ICD_CNT_BASE + {7'h00, s};
      else
        cnt_addr = `ICD_CNT_BASE;
    end
  endfunction

  // ==========================================================
  // regular word decoder
  icd_class_decode u_dec (
    .word         (mem_word),
    .ext          (ext_r),
    .kind         (dk_kind),
    .func         (dk_func),
    .sub          (dk_sub),
    .is_extend    (dk_ext),
    .is_prog_intr (dk_prog)
  );

  // ==========================================================
  // pin synchronisers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      key_a_s1_r  <= 1'b0;
      key_a_s2_r  <= 1'b0;
      key_a_s3_r  <= 1'b0;
      key_b_s1_r  <= 1'b0;
      key_b_s2_r  <= 1'b0;
      key_b_s3_r  <= 1'b0;
      code_a_s1_r <= {`ICD_KEY_W{1'b0}};
      code_a_s2_r <= {`ICD_KEY_W{1'b0}};
      code_b_s1_r <= {`ICD_KEY_W{1'b0}};
      code_b_s2_r <= {`ICD_KEY_W{1'b0}};
      per_s1_r    <= 1'b0;
      per_s2_r    <= 1'b0;
    end else begin
      key_a_s1_r  <= key_press_a;
      key_a_s2_r  <= key_a_s1_r;
      key_a_s3_r  <= key_a_s2_r;
      key_b_s1_r  <= key_press_b;
      key_b_s2_r  <= key_b_s1_r;
      key_b_s3_r  <= key_b_s2_r;
      code_a_s1_r <= key_code_a;
      code_a_s2_r <= code_a_s1_r;
      code_b_s1_r <= key_code_b;
      code_b_s2_r <= code_b_s1_r;
      per_s1_r    <= per_req;
      per_s2_r    <= per_s1_r;
    end
  end

  wire key_a_rise = key_a_s2_r & ~key_a_s3_r;
  wire key_b_rise = key_b_s2_r & ~key_b_s3_r;
  wire key_rise   = key_a_rise | key_b_rise;

  // ==========================================================
  // keyboard channel and request; new press wins over read
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      key_chan_r      <= {`ICD_KEY_W{1'b0}};
      key_chan_full_r <= 1'b0;
    end else if (key_rise) begin
      key_chan_r      <= key_a_rise ? code_a_s2_r : code_b_s2_r;
      key_chan_full_r <= 1'b1;
    end else if (key_chan_rd) begin
      key_chan_full_r <= 1'b0;
    end
  end

  // ==========================================================
  // arbitration among pending involuntary requests
  wire boundary   = (state_r == ST_IDLE);
  wire init_win   = init_pend_r;
  wire rupt_any   = key_irq_r | rupt_req | prog_rupt_r;
  wire rupt_ok    = rupt_any & ~inhibit_r & ~ext_r;
  wire cnt_any    = |cnt_req;
  wire cnt_ok     = cnt_any & first_basic_r;
  wire reg_ok     = mem_valid & ~init_win & ~rupt_ok & ~cnt_ok & ~per_s2_r;
  assign mem_ready = boundary & reg_ok;

  // state sequencing
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (per_s2_r)
          state_nxt = ST_PERI;
        else if (init_win | rupt_ok | cnt_ok | reg_ok)
          state_nxt = ST_BUSY;
      end
      ST_BUSY: begin
        if (instr_done)
          state_nxt = ST_IDLE;
      end
      ST_PERI: begin
        if (instr_done)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ==========================================================
  // issue register and flags
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r        <= ST_IDLE;
      issue_r        <= 1'b0;
      class_r        <= `ICD_CL_REG;
      kind_r         <= `ICD_K_BASIC;
      func_r         <= `ICD_F_SEQ;
      sub_r          <= 2'h0;
      order_r        <= 4'h0;
      addr_r         <= 12'h000;
      ext_r          <= 1'b0;
      inhibit_r      <= 1'b0;
      monitor_stop_r <= 1'b0;
      chan_space_r   <= 1'b0;
      init_pend_r    <= 1'b1;
      prog_rupt_r    <= 1'b0;
      first_basic_r  <= 1'b0;
      key_irq_r      <= 1'b0;
    end else begin
      state_r <= state_nxt;
      issue_r <= 1'b0;
      if (power_on_req | trap_req)
        init_pend_r <= 1'b1;
      if (key_rise)
        key_irq_r <= 1'b1;
      if (state_r == ST_PERI && instr_done)
        monitor_stop_r <= 1'b0;
      if (boundary) begin
        if (per_s2_r) begin
          issue_r        <= 1'b1;
          class_r        <= `ICD_CL_PER;
          func_r         <= `ICD_F_PERI;
          sub_r          <= {1'b0, per_tape};
          monitor_stop_r <= 1'b1;
        end else if (init_win) begin
          issue_r     <= 1'b1;
          class_r     <= `ICD_CL_INV;
          kind_r      <= `ICD_K_BASIC;
          func_r      <= `ICD_F_INTR;
          sub_r       <= 2'h0;
          order_r     <= `ICD_OP_INTR;
          addr_r      <= `ICD_VEC_INIT;
          init_pend_r <= power_on_req | trap_req;
          ext_r       <= 1'b0;
          inhibit_r   <= 1'b0;
          first_basic_r <= 1'b0;
        end else if (rupt_ok) begin
          issue_r   <= 1'b1;
          class_r   <= `ICD_CL_INV;
          kind_r    <= `ICD_K_BASIC;
          func_r    <= `ICD_F_INTR;
          sub_r     <= 2'h1;
          order_r   <= `ICD_OP_INTR;
          inhibit_r <= 1'b1;
          if (key_irq_r) begin
            addr_r    <= `ICD_VEC_KEY;
            key_irq_r <= key_rise;
          end else if (rupt_req) begin
            addr_r <= rupt_vec;
          end else begin
            addr_r      <= `ICD_VEC_PROG;
            prog_rupt_r <= 1'b0;
          end
        end else if (cnt_ok) begin
          issue_r <= 1'b1;
          class_r <= `ICD_CL_INV;
          kind_r  <= `ICD_K_BASIC;
          func_r  <= `ICD_F_CNT;
          order_r <= 4'h0;
          addr_r  <= cnt_addr(cnt_sel);
          first_basic_r <= 1'b0;
          casez (cnt_req)
            4'b???1: sub_r <= 2'h0;
            4'b??10: sub_r <= 2'h1;
            4'b?100: sub_r <= 2'h2;
            default: sub_r <= 2'h3;
          endcase
        end else if (reg_ok) begin
          issue_r       <= 1'b1;
          class_r       <= `ICD_CL_REG;
          kind_r        <= dk_kind;
          func_r        <= dk_func;
          sub_r         <= dk_sub;
          order_r       <= mem_word[`ICD_OP_MSB:`ICD_OP_LSB];
          addr_r        <= mem_word[`ICD_ADR_MSB:`ICD_ADR_LSB];
          chan_space_r  <= (dk_kind == `ICD_K_CHAN);
          first_basic_r <= 1'b1;
          ext_r         <= dk_ext;
          if (dk_prog)
            prog_rupt_r <= 1'b1;
          if (dk_kind == `ICD_K_SPEC && dk_sub == 2'h0)
            inhibit_r <= 1'b1;
          if (dk_kind == `ICD_K_SPEC && dk_sub == 2'h3)
            inhibit_r <= 1'b0;
        end
      end
    end
  end
endmodule // icd_dispatch

// ===== verif/icd_chk_asserts.sv
// concurrent checks on the dispatcher ports
`timescale 1ns/100ps
`include "icd_regs.vh"
module icd_chk (
  input wire              clk,
  input wire              resetn,
  input wire [`ICD_W-1:0] mem_word,
  input wire              mem_ready,
  input wire              instr_done,
  input wire              key_chan_rd,
  input wire              key_chan_full_r,
  input wire              issue_r,
  input wire [1:0]        class_r,
  input wire [1:0]        kind_r,
  input wire [3:0]        func_r,
  input wire [3:0]        order_r,
  input wire [11:0]       addr_r,
  input wire              ext_r,
  input wire              monitor_stop_r,
  input wire              chan_space_r
);
  // ========
  // busy tracking
  reg busy_r;
  // set by an issue, cleared by completion
  always @(posedge clk or negedge resetn)
    if (!resetn)
      busy_r <= 1'b0;
    else if (issue_r)
      busy_r <= 1'b1;
    else if (instr_done)
      busy_r <= 1'b0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ========
  // properties
  property p_busy; busy_r && !instr_done |=> !issue_r; endproperty
  a_busy: assert property (p_busy) else $error("issue while busy");
  property p_take; mem_ready |-> !busy_r; endproperty
  a_take: assert property (p_take) else $error("word taken while busy");
  property p_word; mem_ready && !ext_r && mem_word != 16'h000f |=> issue_r
    && class_r == `ICD_CL_REG && addr_r == $past(mem_word[11:0])
    && order_r == $past(mem_word[15:12]); endproperty
  a_word: assert property (p_word) else $error("regular word fields wrong");
  property p_ext; ext_r && mem_ready |=> !ext_r
    && (kind_r == `ICD_K_EXTRA || kind_r == `ICD_K_CHAN); endproperty
  a_ext: assert property (p_ext) else $error("extended word decoded wrong");
  property p_chan; issue_r && kind_r == `ICD_K_CHAN |-> chan_space_r; endproperty
  a_chan: assert property (p_chan) else $error("channel kind outside channels");
  property p_cnt; issue_r && func_r == `ICD_F_CNT |-> addr_r >= `ICD_CNT_BASE
    && addr_r < `ICD_CNT_BASE + `ICD_NCNT; endproperty
  a_cnt: assert property (p_cnt) else $error("counter address out of range");
  property p_key; key_chan_full_r && !key_chan_rd |=> key_chan_full_r; endproperty
  a_key: assert property (p_key) else $error("key channel lost");
  property p_stop; monitor_stop_r |-> !mem_ready; endproperty
  a_stop: assert property (p_stop) else $error("program word in monitor stop");
  property p_pulse; issue_r |=> !issue_r; endproperty
  a_pulse: assert property (p_pulse) else $error("issue longer than a cycle");
  property p_init; !$past(resetn) |-> ##[1:3] (issue_r && addr_r == `ICD_VEC_INIT); endproperty
  a_init: assert property (p_init) else $error("no start after reset");
endmodule // icd_chk

// ===== verif/icd_mem_model.sv
// program memory and completion model beside the dispatcher
`timescale 1ns/100ps
module icd_mem_model (
  input  wire        clk,
  input  wire        resetn,
  input  wire        offer_en,
  input  wire [15:0] word_in,
  input  wire [3:0]  lat,
  input  wire        mem_ready,
  input  wire        issue_r,
  output reg  [15:0] mem_word,
  output reg         mem_valid,
  output reg         instr_done
);
  reg       took_r;
  reg [3:0] wait_r;
  // the word is handed over at the edge where ready is seen
  always @(posedge clk or negedge resetn)
    if (!resetn)
      took_r <= 1'b0;
    else
      took_r <= mem_valid & mem_ready;
  // one word at a time; an idle bus shows a changing pattern
  always @(negedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_valid <= 1'b0;
      mem_word <= 16'h0000;
      instr_done <= 1'b0;
      wait_r <= 4'h0;
    end else begin
      if (took_r)
        mem_valid <= 1'b0;
      else if (!mem_valid && offer_en)
        mem_valid <= 1'b1;
      if (!mem_valid && offer_en && !took_r)
        mem_word <= word_in;
      else if (!mem_valid || took_r)
        mem_word <= {mem_word[14:0], ~mem_word[15]};
      instr_done <= (wait_r == 4'h1) && !issue_r;
      if (issue_r)
        wait_r <= lat;
      else if (wait_r != 4'h0)
        wait_r <= wait_r - 4'h1;
    end
  end
endmodule // icd_mem_model

// ===== verif/instruction_class_dispatch_tb.sv
// self-checking bench for the instruction class dispatcher
`timescale 1ns/100ps
`include "icd_regs.vh"
module instruction_class_dispatch_tb;
  reg         clk, resetn, key_press_a, key_press_b, key_chan_rd, power_on_req;
  reg         trap_req, rupt_req, per_req, per_tape, offer_en;
  reg  [4:0]  key_code_a, key_code_b, cnt_sel;
  reg  [3:0]  cnt_req, lat;
  reg  [11:0] rupt_vec;
  reg  [15:0] word_in, w;
  wire [15:0] mem_word;
  wire        mem_valid, mem_ready, instr_done, key_chan_full_r, key_irq_r, issue_r;
  wire        ext_r, inhibit_r, monitor_stop_r, chan_space_r;
  wire [4:0]  key_chan_r;
  wire [1:0]  class_r, kind_r, sub_r;
  wire [3:0]  func_r, order_r;
  wire [11:0] addr_r;
  integer     err_count, checked, seed, i, k;
  icd_dispatch icd_dispatch_i (.clk, .resetn, .key_press_a, .key_code_a, .key_press_b,
    .key_code_b, .key_chan_rd, .power_on_req, .trap_req, .rupt_req, .rupt_vec, .cnt_req,
    .cnt_sel, .per_req, .per_tape, .mem_word, .mem_valid, .instr_done, .mem_ready,
    .key_chan_r, .key_chan_full_r, .key_irq_r, .issue_r, .class_r, .kind_r, .func_r,
    .sub_r, .order_r, .addr_r, .ext_r, .inhibit_r, .monitor_stop_r, .chan_space_r);
  icd_mem_model icd_mem_model_i (.clk, .resetn, .offer_en, .word_in, .lat, .mem_ready,
    .issue_r, .mem_word, .mem_valid, .instr_done);
  // ========
  // helpers
  function [11:0] cnt_addr(input [4:0] s);
    cnt_addr = `ICD_CNT_BASE + ((s >= `ICD_NCNT) ? 12'h000 : {7'h00, s});
  endfunction
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task complete_run;
    begin
      if (err_count == 0 && checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // offers one word with a random completion delay
  task offer(input [15:0] wd);
    reg [2:0] r3;
    begin
      r3 = $random(seed);
      @(negedge clk);
      word_in <= wd;
      offer_en <= 1'b1;
      lat <= {1'b0, r3} + 4'h1;
      @(negedge clk);
      offer_en <= 1'b0;
    end
  endtask
  task wait_issue;
    begin
      k = 0;
      while (issue_r !== 1'b1 && k < 80) begin
        @(negedge clk);
        k = k + 1;
      end
      chk("issue", {15'h0, issue_r}, 16'h1);
      @(negedge clk);
    end
  endtask
  task expect_issue(input [1:0] cl, input [11:0] ad);
    begin
      wait_issue;
      chk("class", class_r, cl);
      chk("addr", addr_r, ad);
    end
  endtask
  task run_word(input [15:0] wd);
    begin
      offer(wd);
      expect_issue(`ICD_CL_REG, wd[11:0]);
    end
  endtask
  // ========
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #60000;
    err_count = err_count + 1;
    complete_run;
  end
  // ========
  // scenarios
  initial begin
    seed = 81;
    err_count = 0;
    checked = 0;
    {resetn, key_press_a, key_press_b, key_chan_rd, power_on_req, trap_req} = 6'h00;
    {rupt_req, per_req, per_tape, offer_en} = 4'h0;
    {key_code_a, key_code_b, cnt_sel, cnt_req} = 19'h0;
    lat = 4'h2; // the start interrupt needs a completion too
    rupt_vec = 12'h000;
    word_in = 16'h0000;
    repeat (8) @(posedge clk);
    @(negedge clk);
    resetn <= 1'b1;
    expect_issue(`ICD_CL_INV, `ICD_VEC_INIT);
    for (i = 0; i < 16; i = i + 1) begin
      w = $random(seed);
      if (w[15:12] == 4'h0)
        w[15:12] = 4'h7;
      run_word(w);
      chk("kind", kind_r, `ICD_K_BASIC);
    end
    // every counter kind, lowest request bit wins, boundary selects
    for (i = 0; i < 4; i = i + 1) begin
      w = $random(seed);
      cnt_req <= 4'hf << i;
      cnt_sel <= (i == 3) ? 5'd29 : (i == 2) ? 5'd28 : w[4:0] % 5'd29;
      offer({4'h3, w[11:0]});
      expect_issue(`ICD_CL_INV, cnt_addr(cnt_sel));
      chk("func", func_r, `ICD_F_CNT);
      chk("sub", sub_r, i[1:0]);
      expect_issue(`ICD_CL_REG, w[11:0]);
    end
    cnt_req <= 4'h0;
    // extend then a channel word and an extracode word
    for (i = 0; i < 2; i = i + 1) begin
      w = $random(seed);
      w[15:12] = (i == 0) ? 4'h0 : 4'h9;
      run_word(16'h0006);
      chk("ext", ext_r, 16'h1);
      offer(w);
      wait_issue;
      chk("xkind", kind_r, (i == 0) ? `ICD_K_CHAN : `ICD_K_EXTRA);
      chk("chsp", chan_space_r, (i == 0) ? 16'h1 : 16'h0);
      chk("ext", ext_r, 16'h0);
    end
    for (i = 0; i < 2; i = i + 1) begin
      w = $random(seed);
      key_code_a <= w[4:0];
      key_code_b <= w[4:0];
      key_press_a <= (i == 0);
      key_press_b <= (i == 1);
      expect_issue(`ICD_CL_INV, `ICD_VEC_KEY);
      chk("kfunc", func_r, `ICD_F_INTR);
      chk("kcode", key_chan_r, w[4:0]);
      chk("kfull", key_chan_full_r, 16'h1);
      key_chan_rd <= 1'b1;
      key_press_a <= 1'b0;
      key_press_b <= 1'b0;
      @(negedge clk);
      key_chan_rd <= 1'b0;
      @(negedge clk);
      chk("kread", key_chan_full_r, 16'h0);
      // the interrupt left inhibit set; release it for the next key
      run_word(16'h0003);
    end
    // inhibit holds off a key and an interrupt; then served key first
    run_word(16'h0004);
    chk("inh", inhibit_r, 16'h1);
    w = $random(seed);
    rupt_vec <= w[11:0];
    rupt_req <= 1'b1;
    key_press_a <= 1'b1;
    run_word({4'h2, w[11:0]});
    repeat (6) @(negedge clk);
    chk("kirq", key_irq_r, 16'h1);
    run_word(16'h0003);
    chk("inh", inhibit_r, 16'h0);
    expect_issue(`ICD_CL_INV, `ICD_VEC_KEY);
    key_press_a <= 1'b0;
    run_word(16'h0003);
    expect_issue(`ICD_CL_INV, w[11:0]);
    rupt_req <= 1'b0;
    for (i = 0; i < 2; i = i + 1) begin
      power_on_req <= (i == 0);
      trap_req <= (i == 1);
      @(negedge clk);
      power_on_req <= 1'b0;
      trap_req <= 1'b0;
      expect_issue(`ICD_CL_INV, `ICD_VEC_INIT);
    end
    // keyboard and tape peripheral, a program word waits behind each
    for (i = 0; i < 2; i = i + 1) begin
      lat <= 4'h8;
      per_req <= 1'b1;
      per_tape <= i[0];
      wait_issue;
      chk("pclass", class_r, `ICD_CL_PER);
      chk("mstop", monitor_stop_r, 16'h1);
      per_req <= 1'b0;
      run_word({4'h1, w[11:0]});
      chk("mstop", monitor_stop_r, 16'h0);
    end
    offer(16'h000f);
    wait_issue;
    if (class_r === `ICD_CL_REG)
      wait_issue;
    chk("pint", class_r, `ICD_CL_INV);
    chk("pvec", addr_r, `ICD_VEC_PROG);
    complete_run;
  end
endmodule // instruction_class_dispatch_tb
bind icd_dispatch icd_chk icd_chk_i (.clk, .resetn, .mem_word, .mem_ready, .instr_done,
  .key_chan_rd, .key_chan_full_r, .issue_r, .class_r, .kind_r, .func_r, .order_r, .addr_r,
  .ext_r, .monitor_stop_r, .chan_space_r);
